// ### hw/sacf_top.sv
// serial configuration and result interface of the converter
`timescale 1ns/1ns
module sacf_top #(
  parameter int unsigned NUM_CH   = 8,
  parameter bit          HAS_SHDN = 1'b1
) (
  input  wire logic                       clk_i,
  input  wire logic                       rstn_i,
  input  wire logic                       cs_n_i,
  input  wire logic                       sclk_i,
  input  wire logic                       din_i,
  input  wire logic [sacf_pkg::RES_W-1:0] conv_data_i,
  output logic                            dout_o,
  output logic                            dout_oe_n_o,
  output logic                            conv_start_o,
  output logic                            single_or_pair_flag_o,
  output logic [2:0]                      pos_chan_o,
  output logic [2:0]                      neg_chan_o,
  output logic                            neg_is_common_o,
  output logic                            sel_reserved_o,
  output logic                            polarity_mode_bit_o,
  output logic                            bit_order_select_o,
  output logic                            shutdown_request_bit_o,
  output logic                            system_shutdown_out_n_o
);
  import sacf_pkg::*;

  typedef struct packed {
    logic [1:0]          cs_sy;
    logic [2:0]          ck_sy;
    logic [1:0]          di_sy;
    sacf_state_t         st;
    logic [2:0]          cnt;
    logic [CFG_BITS-1:0] cfg;
    logic [RES_W-1:0]    res;
    logic [IDX_W-1:0]    idx;
    logic                dout;
    logic                oe_n;
    logic                start;
    logic                sgl;
    logic [2:0]          pos;
    logic [2:0]          neg;
    logic                common_reference_input;
    logic                rsv;
    logic                polarity_mode_bit;
    logic                order;
    logic                ps;
    logic                sso_n;
  } sacf_regs_t;

  sacf_regs_t r_r;
  sacf_regs_t r_nxt;

  logic cs_hi;
  logic ck_rise;
  logic ck_fall;
  logic din_s;

  // value of output bit number idx for the current configuration
  function automatic logic out_bit(input logic [IDX_W-1:0] idx,
                                   input logic             order,
                                   input logic             shdn,
                                   input logic [RES_W-1:0] res);
    logic [IDX_W-1:0] k;
    logic             b;
    k = '0;
    b = 1'b0;
    if (shdn) begin
      b = (idx < IDX_FIRST_END);
    end else if (idx < IDX_FIRST_END) begin
      k = IDX_FIRST_END - 5'h01 - idx;
      b = res[k[3:0]];
    end else if (!order && idx < IDX_SECOND_END) begin
      k = idx - (IDX_FIRST_END - 5'h01);
      b = res[k[3:0]];
    end
    return b;
  endfunction : out_bit

  // reserved select only exists on the six-channel build
  function automatic logic sel_is_rsv(input logic [1:0] sel);
    return (NUM_CH == 6) && (sel == SEL_RESERVED);
  endfunction : sel_is_rsv

  // positive input: pair member picked by odd, or the single channel
  function automatic logic [2:0] chan_pos(input logic [1:0] sel,
                                          input logic       odd);
    return {sel, odd};
  endfunction : chan_pos

  // negative input of a pair is the other member of the same pair
  function automatic logic [2:0] chan_neg(input logic [1:0] sel,
                                          input logic       odd);
    return {sel, ~odd};
  endfunction : chan_neg

  // synchronised pin views; first stages feed only second stages
  assign cs_hi   = r_r.cs_sy[1];
  assign ck_rise = r_r.ck_sy[1] & ~r_r.ck_sy[2];
  assign ck_fall = ~r_r.ck_sy[1] & r_r.ck_sy[2];
  assign din_s   = r_r.di_sy[1];

  always_comb begin
    r_nxt       = r_r;
    r_nxt.cs_sy = {r_r.cs_sy[0], cs_n_i};
    r_nxt.ck_sy = {r_r.ck_sy[1:0], sclk_i};
    r_nxt.di_sy = {r_r.di_sy[0], din_i};
    r_nxt.start = 1'b0;
    if (cs_hi) begin
      r_nxt.st   = ST_IDLE;
      r_nxt.oe_n = 1'b1;
      r_nxt.dout = 1'b0;
      r_nxt.cnt  = CNT_RST;
    end else begin
      case (r_r.st)
        ST_IDLE: begin
          r_nxt.st    = ST_SEEK;
          r_nxt.sso_n = 1'b1;
          r_nxt.ps    = 1'b1;
        end

        ST_SEEK: begin
          if (ck_rise && din_s) begin
            r_nxt.st  = ST_CFG;
            r_nxt.cnt = CNT_RST;
          end
        end

        ST_CFG: begin
          if (ck_rise) begin
            r_nxt.cfg = {r_r.cfg[CFG_BITS-2:0], din_s};
            r_nxt.cnt = r_r.cnt + 3'h1;
            if (r_r.cnt == CNT_LAST) begin
              r_nxt.st = ST_NULL;
            end
          end
        end

        ST_NULL: begin
          // decode the captured word once it is complete
          r_nxt.sgl   = r_r.cfg[CFG_SGL];
          r_nxt.polarity_mode_bit   = r_r.cfg[CFG_UNI];
          r_nxt.order = r_r.cfg[CFG_ORDER];
          r_nxt.ps    = r_r.cfg[CFG_PS];
          r_nxt.pos   = chan_pos(r_r.cfg[CFG_SEL_HI:CFG_SEL_LO],
                                 r_r.cfg[CFG_ODD]);
          r_nxt.neg   = chan_neg(r_r.cfg[CFG_SEL_HI:CFG_SEL_LO],
                                 r_r.cfg[CFG_ODD]);
          r_nxt.common_reference_input   = r_r.cfg[CFG_SGL];
          r_nxt.rsv   = sel_is_rsv(r_r.cfg[CFG_SEL_HI:CFG_SEL_LO]);
          if (!r_r.cfg[CFG_PS] && HAS_SHDN) begin
            r_nxt.sso_n = 1'b0;
          end
          if (ck_fall) begin
            r_nxt.st   = ST_OUT;
            r_nxt.dout = 1'b0;
            r_nxt.oe_n = 1'b0;
            r_nxt.idx  = '0;
            r_nxt.start = r_r.cfg[CFG_PS] &&
                          !sel_is_rsv(r_r.cfg[CFG_SEL_HI:CFG_SEL_LO]);
          end
        end

        ST_OUT: begin
          // the core must present the fresh result by this fall
          if (ck_fall) begin
            r_nxt.res  = conv_data_i;
            r_nxt.dout = out_bit('0, r_r.order, !r_r.ps, conv_data_i);
            r_nxt.idx  = 5'h01;
            r_nxt.st   = ST_DONE;
          end
        end

        ST_DONE: begin
          // configuration input is ignored here until select rises
          if (ck_fall) begin
            r_nxt.dout = out_bit(r_r.idx, r_r.order, !r_r.ps,
                                 r_r.res);
            if (r_r.idx != IDX_HOLD) begin
              r_nxt.idx = r_r.idx + 5'h01;
            end
          end
        end

        default: begin
          r_nxt.st = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      r_r       <= '0;
      r_r.cs_sy <= 2'h3;
      r_r.st    <= ST_IDLE;
      r_r.cfg   <= CFG_RST;
      r_r.oe_n  <= 1'b1;
      r_r.ps    <= 1'b1;
      r_r.sso_n <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign dout_o                  = r_r.dout;
  assign dout_oe_n_o             = r_r.oe_n;
  assign conv_start_o            = r_r.start;
  assign single_or_pair_flag_o   = r_r.sgl;
  assign pos_chan_o              = r_r.pos;
  assign neg_chan_o              = r_r.neg;
  assign neg_is_common_o         = r_r.common_reference_input;
  assign sel_reserved_o          = r_r.rsv;
  assign polarity_mode_bit_o     = r_r.polarity_mode_bit;
  assign bit_order_select_o      = r_r.order;
  assign shutdown_request_bit_o  = r_r.ps;
  assign system_shutdown_out_n_o = r_r.sso_n;

endmodule : sacf_top

// ### hw/sacf_pkg.sv
// constants and types for the serial converter control interface
// Summary of operation
// - drive on falling clock, sample on rising
// - configuration in first, then result out
// - shared data wire; host releases after config
// - falling chip select starts the start-bit search
// - first sampled one is start; zeros ignored
// - shift exactly seven configuration bits after start
// - ignore data input until next chip select
// - one null bit, then result on falls
// - result comes from this transfer's conversion
// - chip select high resets the interface
// - four mux bits: single, odd, select high-first
// - pair mode picks 2n/2n+1, odd swaps polarity
// - single mode channel is select*2 plus odd
// - polarity one unipolar binary, zero bipolar
// - order one MSB then zeros, zero adds LSB-first
// - shutdown: twelve ones then zeros, until next select
// - shutdown output low until next select cycle
package sacf_pkg;

  localparam int unsigned CFG_BITS   = 7;
  localparam int unsigned RES_W      = 12;
  localparam int unsigned IDX_W      = 5;
  // positions inside the configuration word, first received bit highest
  localparam int unsigned CFG_SGL    = 6;
  localparam int unsigned CFG_ODD    = 5;
  localparam int unsigned CFG_SEL_HI = 4;
  localparam int unsigned CFG_SEL_LO = 3;
  localparam int unsigned CFG_UNI    = 2;
  localparam int unsigned CFG_ORDER  = 1;
  localparam int unsigned CFG_PS     = 0;
  localparam logic [1:0]  SEL_RESERVED = 2'h3;
  // output bit indices: first pass 0..11, second pass 12..22
  localparam logic [IDX_W-1:0] IDX_FIRST_END  = 5'h0C;
  localparam logic [IDX_W-1:0] IDX_SECOND_END = 5'h17;
  localparam logic [IDX_W-1:0] IDX_HOLD       = 5'h1F;
  localparam logic [2:0]  CNT_RST    = 3'h0;
  localparam logic [2:0]  CNT_LAST   = 3'h6;
  localparam logic [CFG_BITS-1:0] CFG_RST = 7'h01;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEEK = 3'b001,
    ST_CFG  = 3'b010,
    ST_NULL = 3'b011,
    ST_OUT  = 3'b100,
    ST_DONE = 3'b101
  } sacf_state_t;

endpackage : sacf_pkg

// ### test/sacf_checker_assertions.sv
// port assertions for the converter serial interface
`timescale 1ns/1ns
module sacf_checker (
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic       cs_n_i,
  input wire logic       sclk_i,
  input wire logic       dout_o,
  input wire logic       dout_oe_n_o,
  input wire logic       conv_start_o,
  input wire logic       single_or_pair_flag_o,
  input wire logic [2:0] pos_chan_o,
  input wire logic [2:0] neg_chan_o,
  input wire logic       neg_is_common_o,
  input wire logic       sel_reserved_o,
  input wire logic       shutdown_request_bit_o,
  input wire logic       system_shutdown_out_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_oe_idle: assert property (cs_n_i[*6] |-> dout_oe_n_o)
    else $error("data pin driven while deselected");
  a_dout_quiet: assert property (
    dout_oe_n_o && $past(dout_oe_n_o) |-> !dout_o)
    else $error("data nonzero while released");
  a_start_once: assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse too long");
  a_start_ok: assert property (conv_start_o |->
    shutdown_request_bit_o && !sel_reserved_o)
    else $error("start in shutdown or reserved");
  a_start_null: assert property (conv_start_o |->
    $fell(dout_oe_n_o) && !dout_o)
    else $error("start not at null bit");
  a_shdn_pin: assert property (!system_shutdown_out_n_o |->
    !shutdown_request_bit_o)
    else $error("shutdown pin without request");
  a_pair_chan: assert property (
    !dout_oe_n_o && !single_or_pair_flag_o |->
    neg_chan_o == (pos_chan_o ^ 3'h1))
    else $error("pair channels not adjacent");
  a_single_com: assert property (!dout_oe_n_o |->
    neg_is_common_o == single_or_pair_flag_o)
    else $error("common input choice wrong");
  a_dout_fall: assert property ($changed(dout_o) |->
    !sclk_i && !$past(sclk_i, 2))
    else $error("data changed off the falling edge");
endmodule : sacf_checker
bind sacf_top sacf_checker sacf_checker_i (.*);

// ### test/sacf_host.sv
// host model driving chip select, link clock and data
`timescale 1ns/1ns
module sacf_host (
  input  wire logic clk_i,
  input  wire logic dout_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      din_o
);
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o  = 1'b0;
  end
  task automatic bit_io(input logic d, output logic q);
    @(posedge clk_i);
    sclk_o <= 1'b0;
    din_o  <= d;
    repeat (5) @(posedge clk_i);
    q = dout_i;
    sclk_o <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask : bit_io
  task automatic xfer(input int lead, input logic [6:0] cfg,
                      output logic [23:0] got);
    logic q;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    repeat (lead) bit_io(1'b0, q);
    bit_io(1'b1, q);
    for (int i = 6; i >= 0; i--) bit_io(cfg[i], q);
    for (int i = 23; i >= 0; i--) bit_io(i[0], got[i]);
    @(posedge clk_i);
    sclk_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    cs_n_o <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask : xfer
endmodule : sacf_host

// ### test/sacf_top_test.sv
// self-checking bench for the converter serial interface
`timescale 1ns/1ns
module sacf_top_test;
  import sacf_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [RES_W-1:0] conv_data_i = '0;
  logic cs_n_i, sclk_i, din_i, dout_o, dout_oe_n_o, conv_start_o;
  logic single_or_pair_flag_o, neg_is_common_o, sel_reserved_o;
  logic polarity_mode_bit_o, bit_order_select_o, shutdown_request_bit_o;
  logic system_shutdown_out_n_o;
  logic [2:0] pos_chan_o, neg_chan_o;
  logic [6:0] cfgs [6] = '{7'h47, 7'h2D, 7'h79, 7'h13, 7'h5E, 7'h37};
  int err_total = 0;
  int checks_done = 0;
  int starts = 0;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (conv_start_o === 1'b1) starts++;
  sacf_top sacf_top_i (.*);
  sacf_host sacf_host_i (.clk_i, .dout_i(dout_o), .cs_n_o(cs_n_i),
                         .sclk_o(sclk_i), .din_o(din_i));
  task automatic chk(input string what, input logic [23:0] e, g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", what, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    if (err_total == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  initial begin
    logic [6:0] c;
    logic [10:0] t;
    logic [23:0] got, e;
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    chk("rst", 24'h3, {22'h0, dout_oe_n_o, system_shutdown_out_n_o});
    foreach (cfgs[i]) begin
      c = cfgs[i];
      conv_data_i <= 12'h5A3 ^ 12'(i * 273);
      starts = 0;
      sacf_host_i.xfer(i, c, got);
      t = {<<{conv_data_i[11:1]}};
      e = {1'b0, c[0] ? conv_data_i : 12'hFFF, c[0] && !c[1] ? t : 11'h0};
      chk("dout", e, got);
      e = {9'h0, c[6], c[4:3], c[5], c[6] ? 3'h0 : {c[4:3], ~c[5]}, c[6],
           c[2:0], c[0], c[0], 2'h2};
      got = {8'h0, sel_reserved_o, single_or_pair_flag_o, pos_chan_o,
             single_or_pair_flag_o ? 3'h0 : neg_chan_o, neg_is_common_o,
             polarity_mode_bit_o, bit_order_select_o, shutdown_request_bit_o,
             system_shutdown_out_n_o, starts == 1, dout_oe_n_o, dout_o};
      chk("decode", e, got);
    end
    report_and_stop();
  end
  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end
endmodule : sacf_top_test
